//--- dtid_pkg.sv
// Package: function codes, widths and timing constants for the decoder
package dtid_pkg;
  // Function codes handled by this block
  localparam logic [7:0] FC_RESET = 8'h12;
  localparam logic [7:0] FC_START = 8'h14;
  localparam logic [7:0] FC_STOP = 8'h15;
  localparam logic [7:0] FC_DIR = 8'h16;
  localparam logic [7:0] FC_PID_DIS = 8'h17;
  localparam logic [7:0] FC_PID_CLR = 8'h18;
  localparam logic [7:0] FC_UP = 8'h1B;
  localparam logic [7:0] FC_DOWN = 8'h1C;
  localparam logic [7:0] FC_MEM_CLR = 8'h1D;
  localparam logic [7:0] FC_OPER = 8'h1F;
  localparam logic [7:0] FC_SPEED_B1 = 8'h20;
  localparam logic [7:0] FC_OLR = 8'h27;
  localparam logic [7:0] FC_NONE = 8'hFF;
  // Widths and defaults
  localparam int NUM_TERM = 7;
  localparam int FREQ_W = 16;
  localparam int SPEED_BITS = 7;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 16'h0000;
  // Up/down ramp step period
  localparam int CLK_MHZ = 125;
  localparam int RAMP_STEP_US = 10;
  localparam int RAMP_CYCLES = RAMP_STEP_US * CLK_MHZ;
  localparam logic [FREQ_W-1:0] RAMP_STEP = 16'h0001;
  // Run/direction states, Gray along idle-run-decel
  typedef enum logic [1:0] {
    DTID_IDLE = 2'b00,
    DTID_RUN = 2'b01,
    DTID_DECEL = 2'b11
  } dtid_state_t;
endpackage

//--- dtid_sync.sv
// Two-stage synchroniser for one terminal input
`timescale 1ns/1ns
module dtid_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Data
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  // Next values: first stage feeds only the second
  always_comb begin
    nxt_meta = din;
    nxt_sync = meta_ff;
  end

  // Register stages
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;
endmodule

//--- dtid_decoder.sv
// Terminal function decoder for codes 20 to 39 plus reset
`timescale 1ns/1ns
module dtid_decoder
  import dtid_pkg::*;
#(
  parameter int N_TERM = dtid_pkg::NUM_TERM,
  parameter int RAMP_CYC = dtid_pkg::RAMP_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Terminals and their function codes
  input wire logic [N_TERM-1:0] term_in,
  input wire logic [N_TERM*8-1:0] term_code,
  // Configuration and motor status
  input wire logic pid_enable,
  input wire logic [dtid_pkg::FREQ_W-1:0] set_frequency_parameter,
  input wire logic [1:0] cfg_freq_src,
  input wire logic [1:0] cfg_run_src,
  input wire logic [1:0] local_src_code,
  input wire logic motor_stopped,
  // Commands out
  output logic run_cmd,
  output logic dir_fwd,
  output logic decel_req,
  output logic pid_active,
  output logic pid_integ_clr,
  output logic [dtid_pkg::FREQ_W-1:0] updown_freq,
  output logic [1:0] freq_src,
  output logic [1:0] run_src,
  output logic [dtid_pkg::SPEED_BITS-1:0] speed_select,
  output logic overload_limit_on,
  output logic trip_clear,
  output logic powerup_reset
);
  import dtid_pkg::*;

  // ----------------------------------------------------------------
  // Synchronise and decode
  // ----------------------------------------------------------------
  logic [N_TERM-1:0] term_sync;
  logic three_wire_start_input;
  logic three_wire_stop_input;
  logic dir_in;
  logic pid_dis_in;
  logic loop_integrator_clear;
  logic remote_increase_input;
  logic remote_decrease_input;
  logic remote_memory_clear;
  logic operator_override_input;
  logic overload_limit_changeover;
  logic drive_reset_input;
  logic [SPEED_BITS-1:0] speed_in;

  genvar gi;
  generate
    for (gi = 0; gi < N_TERM; gi++) begin : g_sync
      dtid_sync u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(term_in[gi]),
        .dout(term_sync[gi])
      );
    end
  endgenerate

  // OR of terminals carrying a code; none assigned gives zero
  function automatic logic fn_hit(input logic [7:0] code,
                                  input logic [N_TERM-1:0] lv,
                                  input logic [N_TERM*8-1:0] cv);
    logic r;
    r = 1'b0;
    for (int k = 0; k < N_TERM; k++) begin
      if (cv[k*8 +: 8] == code) begin
        r = r | lv[k];
      end
    end
    return r;
  endfunction

  // Decode each function from the synchronised levels
  always_comb begin
    three_wire_start_input = fn_hit(FC_START, term_sync, term_code);
    three_wire_stop_input = fn_hit(FC_STOP, term_sync, term_code);
    dir_in = fn_hit(FC_DIR, term_sync, term_code);
    pid_dis_in = fn_hit(FC_PID_DIS, term_sync, term_code);
    loop_integrator_clear = fn_hit(FC_PID_CLR, term_sync, term_code);
    remote_increase_input = fn_hit(FC_UP, term_sync, term_code);
    remote_decrease_input = fn_hit(FC_DOWN, term_sync, term_code);
    remote_memory_clear = fn_hit(FC_MEM_CLR, term_sync, term_code);
    operator_override_input = fn_hit(FC_OPER, term_sync, term_code);
    overload_limit_changeover = fn_hit(FC_OLR, term_sync, term_code);
    drive_reset_input = fn_hit(FC_RESET, term_sync, term_code);
    for (int b = 0; b < SPEED_BITS; b++) begin
      speed_in[b] = fn_hit(FC_SPEED_B1 + 8'(b), term_sync, term_code);
    end
  end

  // ----------------------------------------------------------------
  // Run and direction control
  // ----------------------------------------------------------------
  dtid_state_t state_ff;
  dtid_state_t nxt_state;
  logic dir_ff;
  logic nxt_dir;

  // Stop wins over start; reset forces output off
  always_comb begin
    nxt_state = state_ff;
    nxt_dir = dir_ff;
    case (state_ff)
      DTID_IDLE: begin
        // A coasting motor must not be reversed under it
        if (motor_stopped) begin
          nxt_dir = dir_in;
        end
        if (three_wire_start_input && !three_wire_stop_input) begin
          nxt_state = DTID_RUN;
        end
      end
      DTID_RUN: begin
        if (three_wire_stop_input) begin
          nxt_state = DTID_IDLE;
        end else if (dir_in != dir_ff) begin
          nxt_state = DTID_DECEL;
        end
      end
      DTID_DECEL: begin
        if (three_wire_stop_input) begin
          nxt_state = DTID_IDLE;
        end else if (motor_stopped) begin
          nxt_dir = dir_in;
          nxt_state = DTID_RUN;
        end
      end
      default: nxt_state = DTID_IDLE;
    endcase
    if (drive_reset_input) begin
      nxt_state = DTID_IDLE;
    end
  end

  // Released start/stop simply leaves state where it was
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= DTID_IDLE;
      dir_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      dir_ff <= nxt_dir;
    end
  end

  assign run_cmd = (state_ff == DTID_RUN);
  assign decel_req = (state_ff == DTID_DECEL);
  assign dir_fwd = dir_ff;

  // ----------------------------------------------------------------
  // Up/down frequency memory
  // ----------------------------------------------------------------
  logic [FREQ_W-1:0] freq_ff;
  logic [FREQ_W-1:0] nxt_freq;
  logic [31:0] tick_cnt_ff;
  logic [31:0] nxt_tick_cnt;
  logic tick;

  // Step timer: one ramp step every RAMP_CYC clocks, 10 us at the default 125 MHz
  always_comb begin
    tick = (tick_cnt_ff == 32'(RAMP_CYC - 1));
    nxt_tick_cnt = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
  end

  // Clear has priority; both directions together cancel
  always_comb begin
    nxt_freq = freq_ff;
    if (remote_memory_clear) begin
      nxt_freq = set_frequency_parameter;
    end else if (tick && remote_increase_input && !remote_decrease_input
                 && freq_ff != {FREQ_W{1'b1}}) begin
      nxt_freq = freq_ff + RAMP_STEP;
    end else if (tick && remote_decrease_input && !remote_increase_input
                 && freq_ff != FREQ_RESET) begin
      nxt_freq = freq_ff - RAMP_STEP;
    end
    // Otherwise hold value
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      freq_ff <= FREQ_RESET;
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      freq_ff <= nxt_freq;
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  assign updown_freq = freq_ff;

  // ----------------------------------------------------------------
  // Registered level commands
  // ----------------------------------------------------------------
  logic pid_act_ff;
  logic nxt_pid_act;
  logic pid_clr_ff;
  logic nxt_pid_clr;
  logic [1:0] fsrc_ff;
  logic [1:0] nxt_fsrc;
  logic [1:0] rsrc_ff;
  logic [1:0] nxt_rsrc;
  logic [SPEED_BITS-1:0] speed_ff;
  logic [SPEED_BITS-1:0] nxt_speed;
  logic olr_ff;
  logic nxt_olr;
  logic rst_ff;
  logic nxt_rst;

  // Level functions, one cycle after synchronisation
  always_comb begin
    nxt_pid_act = pid_enable && !pid_dis_in;
    nxt_pid_clr = loop_integrator_clear;
    nxt_fsrc = operator_override_input ? local_src_code : cfg_freq_src;
    nxt_rsrc = operator_override_input ? local_src_code : cfg_run_src;
    nxt_speed = speed_in;
    nxt_olr = overload_limit_changeover;
    nxt_rst = drive_reset_input;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pid_act_ff <= 1'b0;
      pid_clr_ff <= 1'b0;
      fsrc_ff <= 2'h0;
      rsrc_ff <= 2'h0;
      speed_ff <= '0;
      olr_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else begin
      pid_act_ff <= nxt_pid_act;
      pid_clr_ff <= nxt_pid_clr;
      fsrc_ff <= nxt_fsrc;
      rsrc_ff <= nxt_rsrc;
      speed_ff <= nxt_speed;
      olr_ff <= nxt_olr;
      rst_ff <= nxt_rst;
    end
  end

  assign pid_active = pid_act_ff;
  assign pid_integ_clr = pid_clr_ff;
  assign freq_src = fsrc_ff;
  assign run_src = rsrc_ff;
  assign speed_select = speed_ff;
  assign overload_limit_on = olr_ff;
  assign trip_clear = rst_ff;
  assign powerup_reset = rst_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_stop_halts: assert property (@(posedge clock) disable iff (sys_rst)
    three_wire_stop_input |=> !run_cmd)
    else $error("stop did not halt motor");
  a_start_runs: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == DTID_IDLE && three_wire_start_input
     && !three_wire_stop_input && !drive_reset_input) |=> run_cmd)
    else $error("start did not run motor");
  a_hold_state: assert property (@(posedge clock) disable iff (sys_rst)
    (!three_wire_start_input && !three_wire_stop_input && !drive_reset_input
     && state_ff == DTID_RUN && dir_in == dir_ff) |=> run_cmd)
    else $error("released inputs changed run state");
  a_dir_decel: assert property (@(posedge clock) disable iff (sys_rst)
    (run_cmd && dir_in != dir_ff && !three_wire_stop_input
     && !drive_reset_input) |=> decel_req && $stable(dir_fwd))
    else $error("reverse without deceleration");
  a_coast_dir: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == DTID_IDLE && !motor_stopped) |=> $stable(dir_fwd))
    else $error("direction changed while motor coasting");
  a_pid_bypass: assert property (@(posedge clock) disable iff (sys_rst)
    pid_dis_in |=> !pid_active)
    else $error("pid not bypassed");
  a_pid_clear: assert property (@(posedge clock) disable iff (sys_rst)
    loop_integrator_clear |=> pid_integ_clr)
    else $error("integrator clear missing");
  a_mem_clear: assert property (@(posedge clock) disable iff (sys_rst)
    remote_memory_clear |=> updown_freq == $past(set_frequency_parameter))
    else $error("memory clear did not load set frequency");
  a_freq_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (!remote_memory_clear && !remote_increase_input
     && !remote_decrease_input) |=> $stable(updown_freq))
    else $error("frequency moved without request");
  a_oper_src: assert property (@(posedge clock) disable iff (sys_rst)
    operator_override_input |=> freq_src == $past(local_src_code)
    && run_src == $past(local_src_code))
    else $error("operator override ignored");
  a_sync_delay: assert property (@(posedge clock) disable iff (sys_rst)
    ##3 term_sync == $past(term_in, 2))
    else $error("synchroniser depth wrong");
endmodule

//--- dtid_switch_model.sv
// Switch bank and motor stand-in on the terminal side of the decoder
`timescale 1ns/1ns
module dtid_switch_model #(
  parameter int SPIN_DOWN = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Switch levels chosen by the bench
  input wire logic [6:0] sw_level,
  // Drive commands seen by the motor
  input wire logic run_cmd,
  input wire logic decel_req,
  // Terminal side
  output logic [6:0] term_in,
  output logic motor_stopped
);
  int spin_ff;
  // Switches are plain levels, high means the contact is closed
  assign term_in = sw_level;
  // Motor keeps turning for a while after drive is withdrawn, so the
  // decoder must really wait for the stop report
  always @(negedge clock) begin
    if (sys_rst) begin
      spin_ff <= 0;
      motor_stopped <= 1'b1;
    end else if (run_cmd && !decel_req) begin
      spin_ff <= SPIN_DOWN;
      motor_stopped <= 1'b0;
    end else if (spin_ff > 0) begin
      spin_ff <= spin_ff - 1;
    end else begin
      motor_stopped <= 1'b1;
    end
  end
endmodule

//--- dtid_decoder_tb.sv
// Self-checking bench for the terminal function decoder
`timescale 1ns/1ns
module dtid_decoder_tb;
  import dtid_pkg::*;
  localparam int RC = 4;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] sw_level = 7'h00;
  logic [6:0] term_in;
  logic [55:0] term_code = {7{8'hFF}};
  logic pid_enable = 1'b0;
  logic [15:0] set_frequency_parameter = 16'h0010;
  logic [1:0] cfg_freq_src = 2'h1;
  logic [1:0] cfg_run_src = 2'h2;
  logic [1:0] local_src_code = 2'h3;
  logic motor_stopped, run_cmd, dir_fwd, decel_req, pid_active;
  logic pid_integ_clr, overload_limit_on, trip_clear, powerup_reset;
  logic [15:0] updown_freq, f0;
  logic [1:0] freq_src, run_src;
  logic [6:0] speed_select;
  int fail_count = 0;
  int checked = 0;
  // ----------------------------------------
  // Clock, partner and design
  // ----------------------------------------
  always #4 clock = ~clock;
  dtid_switch_model sw (.clock(clock), .sys_rst(sys_rst),
    .sw_level(sw_level), .run_cmd(run_cmd), .decel_req(decel_req),
    .term_in(term_in), .motor_stopped(motor_stopped));
  dtid_decoder #(.N_TERM(7), .RAMP_CYC(RC)) dut (.clock(clock),
    .sys_rst(sys_rst), .term_in(term_in), .term_code(term_code),
    .pid_enable(pid_enable),
    .set_frequency_parameter(set_frequency_parameter),
    .cfg_freq_src(cfg_freq_src), .cfg_run_src(cfg_run_src),
    .local_src_code(local_src_code), .motor_stopped(motor_stopped),
    .run_cmd(run_cmd), .dir_fwd(dir_fwd), .decel_req(decel_req),
    .pid_active(pid_active), .pid_integ_clr(pid_integ_clr),
    .updown_freq(updown_freq), .freq_src(freq_src), .run_src(run_src),
    .speed_select(speed_select), .overload_limit_on(overload_limit_on),
    .trip_clear(trip_clear), .powerup_reset(powerup_reset));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Switch change at a falling edge, then n falling edges pass
  task automatic drive(input logic [6:0] lv, input int n);
    @(negedge clock);
    sw_level = lv;
    repeat (n) @(negedge clock);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Start, stop and direction on terminals 0, 1 and 2
  task automatic t_run_dir;
    term_code = {{4{8'hFF}}, FC_DIR, FC_STOP, FC_START};
    drive(7'h00, 3);
    chk("dir_rev", 16'h0, {15'h0, dir_fwd});
    drive(7'h01, 2);
    chk("run_early", 16'h0, {15'h0, run_cmd});
    drive(7'h01, 1);
    chk("run_on", 16'h1, {15'h0, run_cmd});
    drive(7'h00, 6);
    chk("run_held", 16'h1, {15'h0, run_cmd});
    drive(7'h04, 3);
    chk("decel", 16'h1, {15'h0, decel_req});
    chk("dir_kept", 16'h0, {15'h0, dir_fwd});
    repeat (20) @(negedge clock);
    chk("dir_fwd", 16'h1, {15'h0, dir_fwd});
    chk("rerun", 16'h1, {15'h0, run_cmd});
    drive(7'h07, 4);
    chk("stop_wins", 16'h0, {15'h0, run_cmd});
    drive(7'h03, 3);
    chk("dir_coast", 16'h1, {15'h0, dir_fwd});
    drive(7'h04, 4);
    chk("stop_held", 16'h0, {15'h0, run_cmd});
  endtask
  // PID gate and integrator clear
  task automatic t_pid;
    term_code = {{5{8'hFF}}, FC_PID_CLR, FC_PID_DIS};
    pid_enable = 1'b1;
    drive(7'h00, 4);
    chk("pid_run", 16'h1, {15'h0, pid_active});
    chk("clr_off", 16'h0, {15'h0, pid_integ_clr});
    drive(7'h01, 4);
    chk("pid_byp", 16'h0, {15'h0, pid_active});
    drive(7'h02, 4);
    chk("clr_on", 16'h1, {15'h0, pid_integ_clr});
    pid_enable = 1'b0;
    drive(7'h00, 4);
    chk("pid_off", 16'h0, {15'h0, pid_active});
  endtask
  // Remote increase, decrease and memory clear
  task automatic t_updown;
    term_code = {{4{8'hFF}}, FC_MEM_CLR, FC_DOWN, FC_UP};
    drive(7'h05, 12);
    chk("clr_wins", 16'h0010, updown_freq);
    drive(7'h01, 20);
    f0 = updown_freq;
    chk("up", 16'h1, {15'h0, (f0 > 16'h0010)});
    drive(7'h00, 4);
    f0 = updown_freq;
    repeat (12) @(negedge clock);
    chk("hold", f0, updown_freq);
    drive(7'h03, 12);
    chk("both", f0, updown_freq);
    drive(7'h02, 20);
    chk("down", 16'h1, {15'h0, (updown_freq < f0)});
    set_frequency_parameter = 16'hBEEF;
    drive(7'h04, 4);
    chk("reload", 16'hBEEF, updown_freq);
  endtask
  // Source override, speed bits, overload and unassigned terminals
  task automatic t_levels;
    term_code = {{6{8'hFF}}, FC_OPER};
    drive(7'h7F, 4);
    chk("oper_f", 16'h3, {14'h0, freq_src});
    chk("oper_r", 16'h3, {14'h0, run_src});
    chk("unused", 16'h0, {9'h0, speed_select});
    drive(7'h00, 4);
    chk("cfg_f", 16'h1, {14'h0, freq_src});
    chk("cfg_r", 16'h2, {14'h0, run_src});
    for (int k = 0; k < 7; k++) begin
      term_code[8*k +: 8] = FC_SPEED_B1 + 8'(k);
    end
    for (int k = 0; k < 7; k++) begin
      drive(7'h01 << k, 4);
      chk("speed", {9'h0, 7'h01 << k}, {9'h0, speed_select});
    end
    term_code[7:0] = FC_OLR;
    drive(7'h01, 4);
    chk("olr_on", 16'h1, {15'h0, overload_limit_on});
    drive(7'h00, 4);
    chk("olr_off", 16'h0, {15'h0, overload_limit_on});
  endtask
  // Reset terminal while running
  task automatic t_reset;
    term_code = {{4{8'hFF}}, FC_RESET, FC_STOP, FC_START};
    drive(7'h01, 4);
    drive(7'h04, 4);
    chk("trip", 16'h1, {15'h0, trip_clear});
    chk("por", 16'h1, {15'h0, powerup_reset});
    chk("out_off", 16'h0, {15'h0, run_cmd});
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    chk("rst_dir", 16'h1, {15'h0, dir_fwd});
    t_run_dir();
    t_pid();
    t_updown();
    t_levels();
    t_reset();
    tally_and_finish();
  end
  // The run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end
endmodule
